// ---- hdl/drvst_cfg.svh ----
// Constants for the output driver control and status block.
// Assumes inclusion by the package and the design file only.
`ifndef DRVST_CFG_SVH
`define DRVST_CFG_SVH
`define DRVST_FRAME_SHORT     5'd16
`define DRVST_FRAME_LONG      5'd24
`define DRVST_ADDR_MSB        15
`define DRVST_RW_BIT          12
`define DRVST_READ_START_EDGE 5'd4
`define DRVST_CRC_POLY        8'h07
`define DRVST_CRC_INIT        8'h00
`define DRVST_DEV_ADDR_RST    3'h0
`define DRVST_RANGE_RST       4'h0
`define DRVST_CMD_CLEAR_BIT   1
`define DRVST_CMD_RESET_BIT   0
`define DRVST_SAMPLE_LAT      2
`endif

// ---- hdl/drvst_core.sv ----
// Control and status logic of a single-channel output driver behind a serial link.
// Assumes core_clk much faster than the link clock; link pins are asynchronous.
`include "drvst_cfg.svh"

// Overview of operation
// - Read only on address match and read flag
// - Data out released; drive from fifth rising edge
// - Release data out at frame select rise
// - Read word: address, zero, controls, zero, flags
// - Four status flags; in software mode any fault pulls alert
// - Hardware mode takes range from pins
// - Hardware mode: three separate fault alerts
// - Check failure sets packet check error
// - Overheat flag follows temperature detector
// - Current open flag follows open detector
// - Voltage short flag follows short detector
// - Software mode alert on four conditions
// - Hardware mode dedicated alert per fault
// - Clear input high forces clear level
// - Effective clear select is pin OR bit
// - Select zero gives zero scale, one midscale
// - Clear release restores programmed value
// - Clear command in control write clears
// - Resistor select bit picks sense resistor
// - Check at frame end; fail discards write
// - Status read clears packet check error
// - Plain frame 16 bits, sampled falling
module drvst_core #(
  parameter logic [2:0] DEVICE_ADDR = `DRVST_DEV_ADDR_RST
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  link_clk,
  input  wire logic                  link_sel_n,
  input  wire logic                  link_din,
  output logic                       link_dout,
  output logic                       link_dout_oe_n,
  input  wire logic                  hw_config_select,
  input  wire logic [3:0]            range_pins,
  input  wire logic                  sense_resistor_pin,
  input  wire logic                  clear_pin,
  input  wire logic                  clear_level_pin,
  input  wire drvst_pkg::drvst_fault_t fault_in,
  output drvst_pkg::drvst_ctrl_t     ctrl_out,
  output logic                       clear_active,
  output logic                       clear_to_midscale,
  output logic                       fault_alert_oe_n,
  output logic                       current_open_alert_oe_n,
  output logic                       voltage_short_alert_oe_n,
  output logic                       overheat_alert_oe_n
);
  import drvst_pkg::*;

  // Two-flop synchronisers for every asynchronous pin.
  // Select resets high and the link clock low, their idle levels, so no false edge follows reset.
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_reg <= 10'h2_00;
      sync2_reg <= 10'h2_00;
    end else begin
      sync1_reg <= {link_sel_n, link_clk, link_din, clear_pin, clear_level_pin, hw_config_select,
                    fault_in.overheat, fault_in.current_open, fault_in.voltage_short, sense_resistor_pin};
      sync2_reg <= sync1_reg;
    end
  end

  wire sel_n_s   = sync2_reg[9];
  wire sclk_s    = sync2_reg[8];
  wire din_s     = sync2_reg[7];
  wire clr_s     = sync2_reg[6];
  wire clear_level_select_s  = sync2_reg[5];
  wire hwmode_s  = sync2_reg[4];
  wire heat_s    = sync2_reg[3];
  wire iopen_s   = sync2_reg[2];
  wire vshort_s  = sync2_reg[1];
  wire rsetpin_s = sync2_reg[0];

  // Edge detection on the synchronised link clock and frame select.
  logic sclk_d_reg;
  logic sel_d_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclk_d_reg <= 1'b0;
      sel_d_reg  <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      sel_d_reg  <= sel_n_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire sel_rise  = sel_n_s & ~sel_d_reg;
  wire sel_fall  = ~sel_n_s & sel_d_reg;

  // Receive shift register, bit counter and CRC, all advanced on falling link edges.
  logic [23:0]  shift_reg;
  logic [4:0]   bitcnt_reg;
  logic [4:0]   risecnt_reg;
  logic [7:0]   crc_reg;
  drvst_state_t state_reg;
  drvst_state_t state_next;
  wire          in_frame  = ~sel_n_s;
  wire [7:0]    crc_fb    = {crc_reg[6:0], 1'b0} ^ ((crc_reg[7] ^ din_s) ? `DRVST_CRC_POLY : 8'h00);
  wire          crc_track = (bitcnt_reg < `DRVST_FRAME_SHORT);
  always_ff @(posedge core_clk) begin
    if (reset || sel_fall) begin
      shift_reg  <= 24'h00_0000;
      bitcnt_reg <= 5'h00;
      crc_reg    <= `DRVST_CRC_INIT;
    end else if (in_frame && sclk_fall) begin
      shift_reg  <= {shift_reg[22:0], din_s};
      bitcnt_reg <= (bitcnt_reg == 5'h1F) ? bitcnt_reg : bitcnt_reg + 5'h01;
      crc_reg    <= crc_track ? crc_fb : crc_reg;
    end
  end

  // Rising link edges seen in the frame; the checks use it to pin where read data starts.
  always_ff @(posedge core_clk) begin
    if (reset || sel_fall) begin
      risecnt_reg <= 5'h00;
    end else if (in_frame && sclk_rise) begin
      risecnt_reg <= (risecnt_reg == 5'h1F) ? risecnt_reg : risecnt_reg + 5'h01;
    end
  end

  // Frame decode at the closing edge of frame select.
  wire        len_short  = (bitcnt_reg == `DRVST_FRAME_SHORT);
  wire        len_long   = (bitcnt_reg == `DRVST_FRAME_LONG);
  wire [15:0] data_word  = len_long ? shift_reg[23:8] : shift_reg[15:0];
  wire        crc_ok     = (shift_reg[7:0] == crc_reg);
  wire        word_valid = len_short | (len_long & crc_ok);
  wire        addr_match = (data_word[`DRVST_ADDR_MSB -: 3] == DEVICE_ADDR);
  wire        is_read    = data_word[`DRVST_RW_BIT];
  wire        frame_end  = sel_rise & ~(state_reg == ST_READ);
  wire        do_write   = frame_end & word_valid & addr_match & ~is_read & ~hwmode_s;
  wire        crc_fail   = frame_end & len_long & ~crc_ok;
  wire        cmd_reset  = do_write & data_word[`DRVST_CMD_RESET_BIT] & (data_word[11:2] == 10'h000);
  wire        cmd_write  = do_write & ~cmd_reset;
  // Early read request detect after the address and read flag have arrived.
  wire        read_req   = in_frame & (bitcnt_reg == `DRVST_READ_START_EDGE) & (shift_reg[3:1] == DEVICE_ADDR)
                           & shift_reg[0];

  // Link state: idle, shifting a frame, or driving read data.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  state_next = sel_fall ? ST_SHIFT : ST_IDLE;
      ST_SHIFT: state_next = sel_rise ? ST_IDLE : ((read_req && !hwmode_s) ? ST_READ : ST_SHIFT);
      ST_READ:  state_next = sel_rise ? ST_IDLE : ST_READ;
      default:  state_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Control register, written only by a valid addressed frame.
  drvst_ctrl_t ctrl_reg;
  logic        clr_cmd_reg;
  always_ff @(posedge core_clk) begin
    if (reset || cmd_reset) begin
      ctrl_reg    <= '0;
      clr_cmd_reg <= 1'b0;
    end else if (cmd_write) begin
      ctrl_reg    <= data_word[11:5];
      clr_cmd_reg <= data_word[`DRVST_CMD_CLEAR_BIT];
    end
  end

  // Packet check error flag: a new failure wins over the read clear.
  logic pec_err_reg;
  logic status_read_done;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pec_err_reg <= 1'b0;
    end else if (crc_fail) begin
      pec_err_reg <= 1'b1;
    end else if (status_read_done) begin
      pec_err_reg <= 1'b0;
    end
  end

  // Read word and output shifting; the word is latched when the read begins.
  logic [15:0] tx_reg;
  logic        dout_reg;
  logic        oe_n_reg;
  wire  [3:0]  status_bits = {pec_err_reg, heat_s, iopen_s, vshort_s};
  wire  [15:0] read_word   = {DEVICE_ADDR, 1'b0, ctrl_reg, 1'b0, status_bits};
  wire         read_enter  = (state_reg == ST_SHIFT) && (state_next == ST_READ);
  assign status_read_done  = (state_reg == ST_READ) && sel_rise;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_reg   <= 16'h0000;
      dout_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (read_enter) begin
      tx_reg   <= read_word;
      oe_n_reg <= 1'b0;
    end else if (state_reg == ST_READ && sclk_rise) begin
      dout_reg <= tx_reg[15];
      tx_reg   <= {tx_reg[14:0], 1'b0};
    end else if (state_reg != ST_READ) begin
      oe_n_reg <= 1'b1;
    end
  end
  assign link_dout      = dout_reg;
  assign link_dout_oe_n = oe_n_reg;

  // Range pins pass their own two-flop synchroniser.
  // The bits are not gray coded, so a pin change may show a mixed code for one cycle.
  logic [3:0] range_s1_reg;
  logic [3:0] range_s2_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      range_s1_reg <= `DRVST_RANGE_RST;
      range_s2_reg <= `DRVST_RANGE_RST;
    end else begin
      range_s1_reg <= range_pins;
      range_s2_reg <= range_s1_reg;
    end
  end

  // Range and resistor come from pins in hardware configuration.
  // Hardware mode has no output enable bit, so the drive is always on there.
  drvst_ctrl_t eff_ctrl;
  wire [3:0]   eff_range = hwmode_s ? range_s2_reg : ctrl_reg.range_code;
  wire         eff_sense_resistor_select  = hwmode_s ? rsetpin_s : ctrl_reg.sense_resistor_select;
  wire         eff_drive = hwmode_s | ctrl_reg.output_drive_on;
  assign eff_ctrl = {eff_range, ctrl_reg.clear_level_select, eff_drive, eff_sense_resistor_select};

  // Output registers; clear overrides drive but programmed values keep updating underneath.
  logic clr_act_reg;
  logic clr_mid_reg;
  drvst_ctrl_t ctrl_out_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_out_reg <= '0;
      clr_act_reg  <= 1'b0;
      clr_mid_reg  <= 1'b0;
    end else begin
      ctrl_out_reg <= eff_ctrl;
      clr_act_reg  <= clr_s | clr_cmd_reg;
      clr_mid_reg  <= clear_level_select_s | ctrl_reg.clear_level_select;
    end
  end
  assign ctrl_out          = ctrl_out_reg;
  assign clear_active      = clr_act_reg;
  assign clear_to_midscale = clr_mid_reg;

  // Open-drain alerts: enable low pulls the line low.
  wire any_fault_sw = pec_err_reg | heat_s | iopen_s | vshort_s;
  assign fault_alert_oe_n         = ~(~hwmode_s & any_fault_sw);
  assign current_open_alert_oe_n  = ~(hwmode_s & iopen_s);
  assign voltage_short_alert_oe_n = ~(hwmode_s & vshort_s);
  assign overheat_alert_oe_n      = ~(hwmode_s & heat_s);

  // Checks on the block's own behaviour.
  property p_read_drive;
    @(posedge core_clk) disable iff (reset) read_enter |=> !link_dout_oe_n;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  property p_release;
    @(posedge core_clk) disable iff (reset) status_read_done |=> ##1 link_dout_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("data out not released");
  property p_idle_tri;
    @(posedge core_clk) disable iff (reset) (state_reg == ST_IDLE) && $past(state_reg == ST_IDLE) |-> link_dout_oe_n;
  endproperty
  a_idle_tri: assert property (p_idle_tri) else $error("data out driven while idle");
  property p_crc_set;
    @(posedge core_clk) disable iff (reset) crc_fail |=> pec_err_reg;
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("check error not set");
  property p_crc_discard;
    @(posedge core_clk) disable iff (reset) crc_fail |=> $stable(ctrl_reg);
  endproperty
  a_crc_discard: assert property (p_crc_discard) else $error("bad frame written");
  property p_read_clear;
    @(posedge core_clk) disable iff (reset) status_read_done && !crc_fail |=> !pec_err_reg;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("check error not cleared");
  property p_sw_alert;
    @(posedge core_clk) disable iff (reset) !hwmode_s && any_fault_sw |-> !fault_alert_oe_n;
  endproperty
  a_sw_alert: assert property (p_sw_alert) else $error("alert not pulled");
  property p_hw_alert;
    @(posedge core_clk) disable iff (reset) hwmode_s |-> fault_alert_oe_n && (current_open_alert_oe_n == !iopen_s);
  endproperty
  a_hw_alert: assert property (p_hw_alert) else $error("hardware alert wrong");
  property p_clear;
    @(posedge core_clk) disable iff (reset) clr_s |=> clear_active;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not applied");
  property p_clear_level_select;
    @(posedge core_clk) disable iff (reset) clear_level_select_s |=> clear_to_midscale;
  endproperty
  a_clear_level_select: assert property (p_clear_level_select) else $error("clear select not ORed");

  // Read data must not start before the fifth rising link edge of the frame.
  property p_first_bit;
    @(posedge core_clk) disable iff (reset)
      (state_reg == ST_READ) && in_frame && sclk_rise |-> (risecnt_reg >= `DRVST_READ_START_EDGE);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("read data shifted too early");
  // In hardware mode the range and resistor follow the synchronised pins one cycle later.
  property p_hw_range;
    @(posedge core_clk) disable iff (reset)
      hwmode_s && $past(hwmode_s) |-> (ctrl_out.range_code == $past(range_s2_reg)) &&
        (ctrl_out.sense_resistor_select == $past(rsetpin_s));
  endproperty
  a_hw_range: assert property (p_hw_range) else $error("hardware range not taken from pins");
  // Hardware mode has no status register, so a read request is never answered there.
  property p_hw_no_read;
    @(posedge core_clk) disable iff (reset)
      hwmode_s && (state_reg == ST_SHIFT) |=> (state_reg != ST_READ);
  endproperty
  a_hw_no_read: assert property (p_hw_no_read) else $error("read answered in hardware mode");
  // The separate alerts stay released outside hardware mode.
  property p_sw_quiet;
    @(posedge core_clk) disable iff (reset)
      !hwmode_s |-> current_open_alert_oe_n && voltage_short_alert_oe_n && overheat_alert_oe_n;
  endproperty
  a_sw_quiet: assert property (p_sw_quiet) else $error("dedicated alert pulled in software mode");
  // The short and overheat alerts each mirror their own detector in hardware mode.
  property p_hw_each;
    @(posedge core_clk) disable iff (reset)
      hwmode_s |-> (voltage_short_alert_oe_n == !vshort_s) && (overheat_alert_oe_n == !heat_s);
  endproperty
  a_hw_each: assert property (p_hw_each) else $error("dedicated alert wrong");
  // A clear command is seen on the clear output two cycles after the write decodes.
  property p_clear_cmd;
    @(posedge core_clk) disable iff (reset)
      cmd_write && data_word[`DRVST_CMD_CLEAR_BIT] |=> ##1 clear_active;
  endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("clear command not applied");
  // With both select sources low the clear goes to zero scale.
  property p_zero_scale;
    @(posedge core_clk) disable iff (reset)
      !clear_level_select_s && !ctrl_reg.clear_level_select |=> !clear_to_midscale;
  endproperty
  a_zero_scale: assert property (p_zero_scale) else $error("clear level not zero scale");
  c_read: cover property (@(posedge core_clk) disable iff (reset) status_read_done);
  c_write: cover property (@(posedge core_clk) disable iff (reset) cmd_write);
  c_crc_fail: cover property (@(posedge core_clk) disable iff (reset) crc_fail);
  c_hw: cover property (@(posedge core_clk) disable iff (reset) hwmode_s && !overheat_alert_oe_n);
  c_clear_cmd: cover property (@(posedge core_clk) disable iff (reset) cmd_write && data_word[`DRVST_CMD_CLEAR_BIT]);
endmodule // drvst_core

// ---- hdl/drvst_pkg.sv ----
// Types shared by the output driver control and status block.
// Assumes the constants header is available on the include path.
`include "drvst_cfg.svh"
package drvst_pkg;
  // Control settings held by the device.
  typedef struct packed {
    logic [3:0] range_code;
    logic       clear_level_select;
    logic       output_drive_on;
    logic       sense_resistor_select;
  } drvst_ctrl_t;
  // Live fault inputs from the analog detectors.
  typedef struct packed {
    logic overheat;
    logic current_open;
    logic voltage_short;
  } drvst_fault_t;
  // Link receive states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_READ  = 3'b100
  } drvst_state_t;
endpackage

// ---- test/drvst_host.sv ----
// Host controller model that drives the serial link of the driver block.
// Assumes core_clk paces the link: half a link period is four core cycles.
module drvst_host (
  input  wire logic core_clk,
  input  wire logic link_dout,
  input  wire logic link_dout_oe_n,
  output logic      link_clk,
  output logic      link_sel_n,
  output logic      link_din
);
  logic drove;
  // A released data line shows the inverse of its last value, so a stale bit never matches.
  wire  line = link_dout_oe_n ? ~link_dout : link_dout;

  // The clock idles low, so the first read bit follows the fifth rising edge.
  initial begin
    link_clk = 1'b0;
    link_sel_n = 1'b1;
    link_din = 1'b0;
    drove = 1'b0;
  end

  // Check value over the data word, MSB first, starting from zero.
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // One frame of 16 bits, or 24 with the check value; bad spoils the check on purpose.
  task automatic xfer(input logic [15:0] w, input logic packet_check, input logic bad, output logic [15:0] rd);
    logic [23:0] sh;
    int          n;
    sh = {w, crc8(w) ^ {7'h00, bad}};
    n = packet_check ? 24 : 16;
    rd = 16'h0000;
    drove = 1'b0;
    link_sel_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      link_din <= sh[23 - i];
      link_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      link_clk <= 1'b0;
      repeat (4) @(posedge core_clk);
      if (!link_dout_oe_n) drove = 1'b1;
      if (i >= 4 && i < 20) rd = {rd[14:0], line};
    end
    link_sel_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask
endmodule // drvst_host

// ---- test/tb.sv ----
// Self-checking bench for the driver control and status block.
// Assumes the package, the design and the host model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drvst_pkg::*;
  localparam logic [2:0] ADDR = 3'h5;
  logic         core_clk, reset, link_clk, link_sel_n, link_din, link_dout, link_dout_oe_n;
  logic         hw_config_select, sense_resistor_pin, clear_pin, clear_level_pin, clear_active;
  logic         clear_to_midscale, fault_alert_oe_n, current_open_alert_oe_n;
  logic         voltage_short_alert_oe_n, overheat_alert_oe_n;
  logic [3:0]   range_pins;
  logic [15:0]  rd;
  drvst_fault_t fault_in, f;
  drvst_ctrl_t  ctrl_out, c;
  integer       seed = 32'haf5fe76a;
  int           errors = 0;
  int           n_tests = 0;

  drvst_core #(.DEVICE_ADDR(ADDR)) dut_u (.core_clk, .reset, .link_clk, .link_sel_n, .link_din,
    .link_dout, .link_dout_oe_n, .hw_config_select, .range_pins, .sense_resistor_pin, .clear_pin,
    .clear_level_pin, .fault_in, .ctrl_out, .clear_active, .clear_to_midscale, .fault_alert_oe_n,
    .current_open_alert_oe_n, .voltage_short_alert_oe_n, .overheat_alert_oe_n);
  drvst_host host_u (.core_clk, .link_dout, .link_dout_oe_n, .link_clk, .link_sel_n, .link_din);

  // The clock runs at 40 MHz.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp=%b got=%b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp=%h got=%h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Control write word with reserved bits zero.
  function automatic logic [15:0] wword(input drvst_ctrl_t k, input logic clr);
    return {ADDR, 1'b0, k, 3'b000, clr, 1'b0};
  endfunction

  // Expected read word: address, zero, controls, zero, check error, flags.
  function automatic logic [15:0] rword(input drvst_ctrl_t k, input logic packet_check, input drvst_fault_t q);
    return {ADDR, 1'b0, k, 1'b0, packet_check, q};
  endfunction

  task automatic read_chk(input drvst_ctrl_t k, input logic packet_check, input drvst_fault_t q);
    host_u.xfer({ADDR, 1'b1, 12'h000}, 1'b1, 1'b0, rd);
    chk_word("readback", rword(k, packet_check, q), rd);
    chk_bit("dout_released", 1'b1, link_dout_oe_n);
  endtask

  // A hang ends the run after far more cycles than the tests need.
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    wrap_up;
  end

  // Main sequence: reset, random traffic, then the corner cases.
  initial begin
    reset = 1'b1;
    hw_config_select = 1'b0;
    range_pins = 4'h0;
    sense_resistor_pin = 1'b0;
    clear_pin = 1'b0;
    clear_level_pin = 1'b0;
    fault_in = 3'b000;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk_bit("dout_idle", 1'b1, link_dout_oe_n);
    for (int i = 0; i < 8; i++) begin
      c = 7'($random(seed));
      f = 3'($random(seed));
      host_u.xfer(wword(c, 1'b0), i[0], 1'b0, rd);
      chk_word("ctrl", {9'h000, c}, {9'h000, ctrl_out});
      fault_in <= f;
      repeat (8) @(posedge core_clk);
      chk_bit("alert", ~|f, fault_alert_oe_n);
      read_chk(c, 1'b0, f);
    end
    fault_in <= 3'b000;
    host_u.xfer({ADDR ^ 3'h1, 1'b1, 12'h000}, 1'b1, 1'b0, rd);
    chk_bit("foreign_read", 1'b0, host_u.drove);
    host_u.xfer({ADDR ^ 3'h2, 13'h0ff0}, 1'b0, 1'b0, rd);
    chk_word("ctrl_foreign", {9'h000, c}, {9'h000, ctrl_out});
    // A spoiled check value must leave the controls alone and flag the error until read.
    host_u.xfer(wword(~c, 1'b0), 1'b1, 1'b1, rd);
    chk_word("ctrl_bad_crc", {9'h000, c}, {9'h000, ctrl_out});
    chk_bit("alert_pec", 1'b0, fault_alert_oe_n);
    read_chk(c, 1'b1, 3'b000);
    chk_bit("alert_cleared", 1'b1, fault_alert_oe_n);
    read_chk(c, 1'b0, 3'b000);
    // Every pairing of level pin and level bit, with writes landing during the clear.
    clear_pin <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      c.clear_level_select = j[0];
      clear_level_pin <= j[1];
      host_u.xfer(wword(c, 1'b0), 1'b0, 1'b0, rd);
      chk_bit("clear_active", 1'b1, clear_active);
      chk_bit("midscale", j[0] | j[1], clear_to_midscale);
    end
    clear_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk_bit("clear_released", 1'b0, clear_active);
    chk_word("ctrl_restored", {9'h000, c}, {9'h000, ctrl_out});
    host_u.xfer(wword(c, 1'b1), 1'b0, 1'b0, rd);
    chk_bit("clear_cmd", 1'b1, clear_active);
    host_u.xfer(wword(c, 1'b0), 1'b0, 1'b0, rd);
    chk_bit("clear_cmd_off", 1'b0, clear_active);
    // A reset command returns the controls to their power-on state.
    host_u.xfer({ADDR, 1'b0, 12'h001}, 1'b0, 1'b0, rd);
    chk_word("ctrl_reset", 16'h0000, {9'h000, ctrl_out});
    read_chk(7'h00, 1'b0, 3'b000);
    // Hardware configuration: pins set the range and each fault has its own alert.
    hw_config_select <= 1'b1;
    // Serial writes are ignored once the pins own the configuration.
    host_u.xfer(wword(7'h04, 1'b0), 1'b0, 1'b0, rd);
    chk_bit("hw_write_refused", 1'b0, ctrl_out.clear_level_select);
    for (int j = 0; j < 4; j++) begin
      range_pins <= 4'($random(seed));
      sense_resistor_pin <= j[0];
      fault_in <= 3'(1 << j);
      repeat (8) @(posedge core_clk);
      chk_word("hw_range", {12'h000, range_pins}, {12'h000, ctrl_out.range_code});
      chk_bit("hw_sense_resistor_select", j[0], ctrl_out.sense_resistor_select);
      chk_bit("hw_open", ~fault_in.current_open, current_open_alert_oe_n);
      chk_bit("hw_short", ~fault_in.voltage_short, voltage_short_alert_oe_n);
      chk_bit("hw_heat", ~fault_in.overheat, overheat_alert_oe_n);
    end
    wrap_up;
  end
endmodule // tb
